// ### asramc_ctrl.sv
/*
  Host-side controller for a 512K x 16 asynchronous static RAM (optionally
  strapped as 1M x 8). Takes one request at a time from a user port and
  plays it out on the memory pins with a fixed strobe length.
  Assumes the memory pins are wired directly, data bus resolved by the
  testbench from data_oe, and user inputs synchronous to clock.
*/
// Behaviour
// - A write is chip selects active and write strobe low, lanes chosen by the low-active lane selects.
// - A read is chip selects active, output gate low, write strobe high, low byte on lines 0 to 7.
// - The board holds the width select high for word-wide 512K x 16 operation.
// - With width select low the memory is 1M x 8 with an extra address bit and lanes unused.
`timescale 1ns/100ps
`include "asramc_params.svh"

module asramc_ctrl (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rstn,
  // user request
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire logic                       req_write,
  input  wire logic [`ASRAMC_ADDR_W:0]    req_addr,
  input  wire logic [`ASRAMC_DATA_W-1:0]  req_wdata,
  input  wire logic [1:0]                 req_lane,
  input  wire logic                       byte_mode,
  // user answer
  output logic                            rsp_valid,
  output logic [`ASRAMC_DATA_W-1:0]       rsp_rdata,
  // memory pins
  output logic [`ASRAMC_ADDR_W-1:0]       mem_addr,
  output logic                            extra_address_bit,
  output logic                            chip_select_active_low,
  output logic                            chip_select_active_high,
  output logic                            output_gate_n,
  output logic                            write_strobe_n,
  output logic                            upper_lane_select_n,
  output logic                            lower_lane_select_n,
  output logic                            width_select,
  output logic [`ASRAMC_DATA_W-1:0]       data_out,
  output logic                            data_oe,
  input  wire logic [`ASRAMC_DATA_W-1:0]  data_in
);
  import asramc_pkg::*;

  // ***************************************************************
  // state and captured request
  // ***************************************************************
  asramc_state_type                state;
  asramc_state_type                next_state;
  logic                            is_write;
  logic                            is_byte;
  logic [1:0]                      lane;

  wire logic take       = (state == ASRAMC_IDLE) && req_valid;
  wire logic timer_done;
  wire logic enter_strb = (state == ASRAMC_SETUP);
  wire logic finish     = (state == ASRAMC_STROBE) && timer_done;

  always_comb begin
    next_state = state;
    case (state)
      ASRAMC_IDLE:   if (req_valid) next_state = ASRAMC_SETUP;
      ASRAMC_SETUP:  next_state = ASRAMC_STROBE;
      ASRAMC_STROBE: if (timer_done) next_state = ASRAMC_DONE;
      ASRAMC_DONE:   next_state = ASRAMC_IDLE;
      default:       next_state = ASRAMC_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= ASRAMC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // strobe held for the access time rounded up to whole cycles
  asramc_timer u_timer (
    .clock      (clock),
    .rstn       (rstn),
    .load       (enter_strb),
    .load_value (asramc_count_type'(`ASRAMC_ACCESS_CYC - 1)),
    .expired    (timer_done)
  );

  // ***************************************************************
  // address, strap and lane capture
  // ***************************************************************
  // byte mode: lane selects float-unused, so the upper is driven high (inactive) and the lower low
  wire logic [1:0] next_lane = req_lane;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_addr          <= '0;
      extra_address_bit <= 1'b0;
      is_write          <= 1'b0;
      is_byte           <= 1'b0;
      lane              <= 2'h0;
      data_out          <= '0;
    end else if (take) begin
      mem_addr          <= req_addr[`ASRAMC_ADDR_W-1:0];
      extra_address_bit <= byte_mode ? req_addr[`ASRAMC_ADDR_W] : 1'b0;
      is_write          <= req_write;
      is_byte           <= byte_mode;
      lane              <= next_lane;
      data_out          <= req_wdata;
    end
  end

  // the width strap follows byte_mode only between accesses
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      width_select <= 1'b1;
    end else if (state == ASRAMC_IDLE) begin
      width_select <= !byte_mode;
    end
  end

  // ***************************************************************
  // pin strobes
  // ***************************************************************
  wire logic active    = (state == ASRAMC_SETUP) || (state == ASRAMC_STROBE);
  wire logic strobe    = (state == ASRAMC_STROBE);
  wire logic lane_lo   = active && (is_byte || lane[0]);
  wire logic lane_hi   = active && !is_byte && lane[1];

  // both chip selects move together so a single-select part sees the same
  assign chip_select_active_low  = !active;
  assign chip_select_active_high = active;
  assign write_strobe_n          = !(strobe && is_write);
  assign output_gate_n           = !(active && !is_write);
  assign lower_lane_select_n     = !lane_lo;
  assign upper_lane_select_n     = !lane_hi;
  // drive the bus only while writing; memory floats then, never a clash
  assign data_oe                 = active && is_write;

  // ***************************************************************
  // read capture and answer
  // ***************************************************************
  // the address is held steady throughout, so the memory may idle its
  // internals without the host noticing
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rsp_rdata <= '0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= finish;
      if (finish && !is_write) begin
        rsp_rdata[`ASRAMC_BYTE_W-1:0] <= lane_lo ? data_in[`ASRAMC_BYTE_W-1:0] : '0;
        rsp_rdata[`ASRAMC_DATA_W-1:`ASRAMC_BYTE_W] <=
          lane_hi ? data_in[`ASRAMC_DATA_W-1:`ASRAMC_BYTE_W] : '0;
      end
    end
  end

  assign req_ready = (state == ASRAMC_IDLE);

  // ***************************************************************
  // checks
  // ***************************************************************
  chk_write_no_read: assert property (@(posedge clock) disable iff (!rstn)
    !write_strobe_n |-> output_gate_n && data_oe)
    else $error("write strobe with output gate low or bus undriven");

  chk_idle_deselect: assert property (@(posedge clock) disable iff (!rstn)
    state == ASRAMC_IDLE |-> chip_select_active_low && !chip_select_active_high && !data_oe)
    else $error("chip selected while idle");

  chk_read_gate: assert property (@(posedge clock) disable iff (!rstn)
    take && !req_write |=> !output_gate_n && write_strobe_n && !chip_select_active_low)
    else $error("read cycle pins wrong");

  chk_strobe_len: assert property (@(posedge clock) disable iff (!rstn)
    $rose(strobe) |-> strobe [*5] ##1 !strobe)
    else $error("strobe length not access time");

  chk_answer_time: assert property (@(posedge clock) disable iff (!rstn)
    take |-> ##7 rsp_valid)
    else $error("answer not seven cycles after request");

  chk_byte_lanes: assert property (@(posedge clock) disable iff (!rstn)
    is_byte && active |-> upper_lane_select_n && !lower_lane_select_n)
    else $error("lane selects wrong in byte mode");

  chk_word_strap: assert property (@(posedge clock) disable iff (!rstn)
    active && !is_byte |-> width_select && !extra_address_bit)
    else $error("word mode strap or extra bit wrong");

  chk_addr_stable: assert property (@(posedge clock) disable iff (!rstn)
    active && $past(active) |-> $stable(mem_addr))
    else $error("address moved during access");

  chk_high_lane: assert property (@(posedge clock) disable iff (!rstn)
    take && !byte_mode && req_lane[1] |=> !upper_lane_select_n)
    else $error("upper lane not selected");

  // one access at a time: busy from setup through done, then free again
  chk_ready_busy: assert property (@(posedge clock) disable iff (!rstn)
    take |=> !req_ready [*7] ##1 req_ready)
    else $error("ready not low for the whole access");

  chk_data_hold: assert property (@(posedge clock) disable iff (!rstn)
    data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("write data moved while driven");

  chk_gate_float: assert property (@(posedge clock) disable iff (!rstn)
    !output_gate_n |-> !data_oe && write_strobe_n)
    else $error("bus driven while memory output gated on");

  chk_lanes_idle: assert property (@(posedge clock) disable iff (!rstn)
    !active |-> upper_lane_select_n && lower_lane_select_n && output_gate_n && write_strobe_n)
    else $error("strobe or lane active between accesses");

  chk_byte_strap: assert property (@(posedge clock) disable iff (!rstn)
    active && is_byte |-> !width_select)
    else $error("byte mode access with word strap");

endmodule : asramc_ctrl

// ### asramc_ctrl_tb.sv
/*
  Self-checking bench for the SRAM host controller with its memory model.
  Assumes the design files and asramc_params.svh are compiled first.
*/
`timescale 1ns/100ps
`include "asramc_params.svh"

module asramc_ctrl_tb;
  logic clock = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0, byte_mode = 1'b0;
  logic [19:0] req_addr = 20'h00000;
  logic [15:0] req_wdata = 16'h0000, data_out, sram_q, mem_q;
  logic [1:0]  req_lane = 2'h3;
  logic [18:0] mem_addr;
  logic req_ready, rsp_valid, extra_address_bit, chip_select_active_low, chip_select_active_high;
  logic output_gate_n, write_strobe_n, upper_lane_select_n, lower_lane_select_n, width_select, data_oe;
  logic [15:0] rsp_rdata;
  int mismatches = 0, checked = 0;
  wire [15:0] dq = data_oe ? data_out : sram_q;

  always #5 clock = ~clock;

  asramc_ctrl u_asramc_ctrl (.clock(clock), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lane(req_lane),
    .byte_mode(byte_mode), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
    .extra_address_bit(extra_address_bit), .chip_select_active_low(chip_select_active_low),
    .chip_select_active_high(chip_select_active_high), .output_gate_n(output_gate_n),
    .write_strobe_n(write_strobe_n), .upper_lane_select_n(upper_lane_select_n),
    .lower_lane_select_n(lower_lane_select_n), .width_select(width_select), .data_out(data_out),
    .data_oe(data_oe), .data_in(dq));

  asramc_sram_model u_asramc_sram_model (.clock(clock), .mem_addr(mem_addr),
    .extra_address_bit(extra_address_bit), .chip_select_active_low(chip_select_active_low),
    .chip_select_active_high(chip_select_active_high), .output_gate_n(output_gate_n),
    .write_strobe_n(write_strobe_n), .upper_lane_select_n(upper_lane_select_n),
    .lower_lane_select_n(lower_lane_select_n), .width_select(width_select), .dq_in(dq), .dq_out(sram_q));

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error %0t %s", $time, m);
    end
  endtask : chk

  // one transfer; pins are judged mid-strobe, answer latency counted in cycles
  task automatic xfer(input logic wr, input logic [19:0] a, input logic [15:0] d, input logic [1:0] ln);
    int n;
    n = 0;
    @(negedge clock);
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_lane = ln;
    @(negedge clock);
    req_valid = 1'b0;
    n = 1;
    chk(req_ready === 1'b0, "ready while busy");
    while (rsp_valid !== 1'b1 && n < 20) begin
      if (n == 3) begin
        chk(chip_select_active_low === 1'b0 && chip_select_active_high === 1'b1, "not selected");
        chk(write_strobe_n === !wr && data_oe === wr, "strobe or drive wrong");
        chk(output_gate_n === wr, "output gate wrong");
      end
      @(negedge clock);
      n++;
    end
    chk(n == 7, "answer latency");
    mem_q = rsp_rdata;
  endtask : xfer

  task automatic t_reset_idle;
    chk(chip_select_active_low === 1'b1 && chip_select_active_high === 1'b0, "selected idle");
    chk(data_oe === 1'b0 && width_select === 1'b1, "idle drive or width");
    chk(req_ready === 1'b1 && rsp_valid === 1'b0 && write_strobe_n === 1'b1, "reset ready or strobe");
  endtask : t_reset_idle

  task automatic t_word_lanes;
    xfer(1'b1, 20'h7FFFF, 16'hA55A, 2'h3);
    xfer(1'b1, 20'h00000, 16'h1234, 2'h3);
    xfer(1'b1, 20'h7FFFF, 16'hFFC3, 2'h1);
    xfer(1'b0, 20'h7FFFF, 16'h0000, 2'h3);
    chk(mem_q === 16'hA5C3, "word readback");
    xfer(1'b0, 20'h7FFFF, 16'h0000, 2'h2);
    chk(mem_q === 16'hA500, "upper lane read");
    xfer(1'b0, 20'h00000, 16'h0000, 2'h1);
    chk(mem_q === 16'h0034, "lower lane read");
  endtask : t_word_lanes

  task automatic t_byte_mode;
    byte_mode = 1'b1;
    xfer(1'b1, 20'h80005, 16'h003C, 2'h3);
    chk(width_select === 1'b0, "width strap");
    xfer(1'b1, 20'h00005, 16'h00C3, 2'h3);
    xfer(1'b0, 20'h80005, 16'h0000, 2'h3);
    chk(mem_q[7:0] === 8'h3C, "byte high half");
    xfer(1'b0, 20'h00005, 16'h0000, 2'h3);
    chk(mem_q[7:0] === 8'hC3, "byte low half");
    byte_mode = 1'b0;
    xfer(1'b0, 20'h7FFFF, 16'h0000, 2'h3);
    chk(mem_q === 16'hA5C3 && width_select === 1'b1, "word mode back");
  endtask : t_byte_mode

  // reset cut into a write: pins drop at once and the next access still lands
  task automatic t_mid_reset;
    @(negedge clock);
    req_valid = 1'b1;
    req_write = 1'b1;
    req_addr = 20'h00100;
    req_wdata = 16'hBEEF;
    req_lane = 2'h3;
    @(negedge clock);
    req_valid = 1'b0;
    repeat (2) @(negedge clock);
    chk(write_strobe_n === 1'b0 && data_oe === 1'b1, "write not under way");
    rstn = 1'b0;
    @(posedge clock);
    t_reset_idle();
    @(negedge clock);
    rstn = 1'b1;
    xfer(1'b1, 20'h00100, 16'h5AC3, 2'h3);
    xfer(1'b0, 20'h00100, 16'h0000, 2'h3);
    chk(mem_q === 16'h5AC3, "access after reset");
  endtask : t_mid_reset

  task automatic results;
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (4) @(posedge clock);
    t_reset_idle();
    @(negedge clock);
    rstn = 1'b1;
    t_word_lanes();
    t_byte_mode();
    t_mid_reset();
    results();
  end

  initial begin
    #50000;
    mismatches++;
    results();
  end
endmodule : asramc_ctrl_tb

// ### asramc_params.svh
/*
  Constants for the asynchronous SRAM host controller: pin-cycle timing counts,
  data and address widths, timer count width.
  Assumes it is included by bare name from the controller files.
*/
`ifndef ASRAMC_PARAMS_SVH
`define ASRAMC_PARAMS_SVH

`define ASRAMC_ADDR_W      19
`define ASRAMC_DATA_W      16
`define ASRAMC_BYTE_W      8
`define ASRAMC_CLK_PERIOD_NS 10
`define ASRAMC_ACCESS_NS   45
`define ASRAMC_ACCESS_CYC  ((`ASRAMC_ACCESS_NS + `ASRAMC_CLK_PERIOD_NS - 1) / `ASRAMC_CLK_PERIOD_NS)
`define ASRAMC_CNT_W       4

`endif

// ### asramc_pkg.sv
/*
  Types for the asynchronous SRAM host controller.
  Assumes asramc_params.svh is on the include path.
*/
`include "asramc_params.svh"

package asramc_pkg;

  typedef enum logic [1:0] {
    ASRAMC_IDLE,
    ASRAMC_SETUP,
    ASRAMC_STROBE,
    ASRAMC_DONE
  } asramc_state_type;

  typedef logic [`ASRAMC_CNT_W-1:0] asramc_count_type;

endpackage : asramc_pkg

// ### asramc_sram_model.sv
/*
  Partner model of the word-wide or byte-wide asynchronous static RAM.
  Assumes the bench resolves the data lines from the controller's data_oe.
*/
`timescale 1ns/100ps
`include "asramc_params.svh"

module asramc_sram_model (
  // pattern clock
  input  wire logic                      clock,
  // memory pins
  input  wire logic [`ASRAMC_ADDR_W-1:0] mem_addr,
  input  wire logic                      extra_address_bit,
  input  wire logic                      chip_select_active_low,
  input  wire logic                      chip_select_active_high,
  input  wire logic                      output_gate_n,
  input  wire logic                      write_strobe_n,
  input  wire logic                      upper_lane_select_n,
  input  wire logic                      lower_lane_select_n,
  input  wire logic                      width_select,
  // data lines
  input  wire logic [`ASRAMC_DATA_W-1:0] dq_in,
  output logic      [`ASRAMC_DATA_W-1:0] dq_out
);
  logic [7:0]  lo    [0:524287];
  logic [7:0]  hi    [0:524287];
  logic [7:0]  bytes [0:1048575];
  logic [15:0] pat = 16'h5AA5;
  wire         bm  = ~width_select;
  wire         sel = ~chip_select_active_low & chip_select_active_high
                     & (bm | ~(upper_lane_select_n & lower_lane_select_n));
  wire         wr  = sel & ~write_strobe_n;
  wire         rd  = sel & ~output_gate_n & write_strobe_n;
  wire [19:0]  ba  = {extra_address_bit, mem_addr};
  // released lines toggle each cycle so a stale value never reads as valid
  always @(posedge clock) pat <= ~pat;
  // writes land on the clock while the strobe is low, so the bus letting go in
  // the same step as the strobe rising never slips a released value in
  always @(posedge clock) begin
    if (wr && bm) bytes[ba] <= dq_in[7:0];
    if (wr && !bm && !lower_lane_select_n) lo[mem_addr] <= dq_in[7:0];
    if (wr && !bm && !upper_lane_select_n) hi[mem_addr] <= dq_in[15:8];
  end
  always @* begin
    dq_out = pat;
    if (rd && bm) dq_out[7:0] = bytes[ba];
    if (rd && !bm && !lower_lane_select_n) dq_out[7:0] = lo[mem_addr];
    if (rd && !bm && !upper_lane_select_n) dq_out[15:8] = hi[mem_addr];
  end
endmodule : asramc_sram_model

// ### asramc_timer.sv
/*
  Cycle counter for the controller's strobe phase: loads a count and pulses
  expired when it reaches zero.
  Assumes one clock, active-low asynchronous reset.
*/
`timescale 1ns/100ps

module asramc_timer (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rstn,
  // control
  input  wire logic                  load,
  input  wire asramc_pkg::asramc_count_type load_value,
  // status
  output logic                       expired
);
  import asramc_pkg::*;

  asramc_count_type count;
  logic             running;

  wire logic at_end = running && (count == '0);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count   <= '0;
      running <= 1'b0;
    end else if (load) begin
      count   <= load_value;
      running <= 1'b1;
    end else if (at_end) begin
      running <= 1'b0;
    end else if (running) begin
      count   <= count - 1'b1;
    end
  end

  assign expired = at_end;

endmodule : asramc_timer
